/* File: hw/sbt_map.vh */
`ifndef SBT_MAP_VH
`define SBT_MAP_VH
// clock and time base
`define SBT_CLK_HZ          10000000
`define SBT_MS_CYCLES       (`SBT_CLK_HZ / 1000)
// sleep timing
`define SBT_SLEEP_DEF_MIN   6'h0f
`define SBT_SLEEP_MAX_MIN   6'h32
`define SBT_SEC_PER_MIN     16'h003c
`define SBT_MS_PER_SEC      16'h03e8
`define SBT_FLASH_PERIOD_S  16'h0005
`define SBT_FLASH_ON_MS     16'h0064
`define SBT_SLEEP_BEEP_MS   16'h03e8
`define SBT_POWEROFF_HOURS  16'h0006
`define SBT_SEC_PER_HOUR    16'h0e10
// beeper timing limits and defaults
`define SBT_BEEP_ON_MIN_MS  11'h064
`define SBT_BEEP_ON_MAX_MS  11'h5dc
`define SBT_BEEP_ON_DEF_MS  11'h12c
`define SBT_BEEP_OFF_DEF_MS 11'h2bc
// motion beep modes
`define SBT_MB_NONE         2'h0
`define SBT_MB_REVERSE      2'h1
`define SBT_MB_ANY          2'h2
// throttle types
`define SBT_TT_BIDIR        2'h0
`define SBT_TT_SINGLE       2'h1
`define SBT_TT_UNIPOLAR     2'h2
// wake styles
`define SBT_WAKE_KEY_THR    1'b0
`define SBT_WAKE_KEY_ONLY   1'b1
`endif

/* File: hw/sbt_tick.v */
`timescale 1ns/100ps
// divides the system clock to a one-cycle tick every DIV cycles
module sbt_tick #(
  parameter DIV = 10000
) (
  input  wire mclk_in,  // system clock
  input  wire rst_n_in, // sync reset, active low
  output reg  tick_out  // one-cycle pulse
);
  reg [31:0] cnt_q;

  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q    <= 32'h0;
      tick_out <= 1'b0;
    end
    else if (cnt_q == DIV - 1)
    begin
      cnt_q    <= 32'h0;
      tick_out <= 1'b1;
    end
    else
    begin
      cnt_q    <= cnt_q + 32'h1;
      tick_out <= 1'b0;
    end
  end
endmodule

/* File: hw/sbt_core.v */
`timescale 1ns/100ps
`include "sbt_map.vh"

// Contract
// - sleep after timeout minutes at neutral
// - asleep: drive commands ignored
// - key+throttle wake: flash status every 5s
// - zero timeout disables sleep
// - key only: wake on key off-on
// - key+throttle: key or throttle wakes
// - swap inverts bidirectional throttle polarity
// - motor reverse flips motor only
// - master enable off silences all beeps
// - fault beeps equal flash code count
// - one second beep on sleep entry
// - reverse beeper: beep in reverse motion
// - any-motion mode overrides reverse setting
// - motion mode: none, reverse, any
// - beep on/off phases programmable
// - beep below battery cut-off
// - sleep on fault only when enabled
// - never sleep on throttle/neutral fault
// - power off after six hours asleep
// - bidirectional: mid neutral, sides give direction
// - single-ended: speed only, switch direction
// - uni-polar: either side, switch direction
module sbt_core #(
  parameter MS_DIV = `SBT_MS_CYCLES
) (
  input  wire        mclk_in,            // 10 MHz clock
  input  wire        rst_n_in,           // sync reset, active low
  input  wire        key_on_in,          // key switch pin
  input  wire        thr_neutral_in,     // throttle in neutral window
  input  wire        thr_side_in,        // deflection side: 1 = reverse side
  input  wire [7:0]  thr_mag_in,         // throttle magnitude from neutral
  input  wire        fwd_rev_sw_in,      // direction switch pin: 1 = reverse
  input  wire        fault_in,           // any fault or inhibit active
  input  wire        throttle_fault_in,  // throttle fault active
  input  wire        neutral_at_powerup_fault_in, // out-of-neutral at power-up
  input  wire [3:0]  flash_code_in,      // flash code shown, 0 = none
  input  wire        batt_low_in,        // battery below cut-off
  input  wire        moving_in,          // vehicle in motion
  input  wire [5:0]  sleep_min_in,       // sleep timeout minutes
  input  wire        wake_style_in,      // 0 key+throttle, 1 key only
  input  wire        swap_dir_in,        // swap throttle direction
  input  wire        motor_rev_in,       // motor reverse setting
  input  wire [1:0]  thr_type_in,        // throttle type
  input  wire        beep_en_in,         // master beeper enable
  input  wire        flash_beep_en_in,   // flash code beeper
  input  wire        sleep_beep_en_in,   // sleep beeper
  input  wire        rev_beep_en_in,     // reverse beeper
  input  wire [1:0]  motion_beep_in,     // motion beep mode
  input  wire        dd_beep_en_in,      // deep discharge beeper
  input  wire [10:0] beep_on_ms_in,      // beep on time ms
  input  wire [10:0] beep_off_ms_in,     // beep off time ms
  input  wire        sleep_on_fault_in,  // allow sleep on fault
  input  wire        poweroff_en_in,     // power off after sleep
  output reg         asleep_out,         // sleep state
  output reg  [7:0]  drive_mag_out,      // speed demand
  output reg         drive_rev_out,      // commanded direction reverse
  output reg         motor_rev_out,      // motor polarity reverse
  output reg         beeper_out,         // beeper drive
  output reg         status_flash_out,   // sleep flash on status light
  output reg         power_off_out       // self power-off request
);
  localparam ST_AWAKE = 2'b01;
  localparam ST_SLEEP = 2'b10;

  // pin synchronisers
  reg [1:0] key_s_q;
  reg [1:0] thr_s_q;
  reg [1:0] sw_s_q;
  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      key_s_q <= 2'b00;
      thr_s_q <= 2'b11;
      sw_s_q  <= 2'b00;
    end
    else
    begin
      key_s_q <= {key_s_q[0], key_on_in};
      thr_s_q <= {thr_s_q[0], thr_neutral_in};
      sw_s_q  <= {sw_s_q[0], fwd_rev_sw_in};
    end
  end
  wire key_s = key_s_q[1];
  wire thr_n = thr_s_q[1];
  wire sw_rev = sw_s_q[1];

  wire ms_tick;
  sbt_tick #(.DIV(MS_DIV)) u_ms (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .tick_out (ms_tick)
  );

  reg [1:0]  state_q;
  reg [9:0]  ms_q;
  reg [15:0] sec_q;
  reg [5:0]  min_q;
  reg [15:0] slp_sec_q;
  reg [2:0]  slp_hr_q;
  reg        key_prev_q;
  reg        key_off_seen_q;
  reg [15:0] flash_ms_q;
  reg        enter_q;
  wire       sec_tick = ms_tick && (ms_q == `SBT_MS_PER_SEC - 16'h1);

  wire fault_block = (fault_in && !sleep_on_fault_in) ||
                     throttle_fault_in || neutral_at_powerup_fault_in;
  wire sleep_ok = (sleep_min_in != 6'h00) && !fault_block;
  wire key_cycle = key_off_seen_q && key_s && !key_prev_q;
  wire wake = key_cycle || ((wake_style_in == `SBT_WAKE_KEY_THR) && !thr_n);

  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      state_q        <= ST_AWAKE;
      ms_q           <= 10'h0;
      sec_q          <= 16'h0;
      min_q          <= 6'h0;
      slp_sec_q      <= 16'h0;
      slp_hr_q       <= 3'h0;
      key_prev_q     <= 1'b0;
      key_off_seen_q <= 1'b0;
      flash_ms_q     <= 16'h0;
      enter_q        <= 1'b0;
      asleep_out     <= 1'b0;
      status_flash_out <= 1'b0;
      power_off_out  <= 1'b0;
    end
    else
    begin
      key_prev_q <= key_s;
      enter_q    <= 1'b0;
      if (ms_tick)
        ms_q <= sec_tick ? 10'h0 : ms_q + 10'h1;
      case (state_q)
        ST_AWAKE:
        begin
          status_flash_out <= 1'b0;
          slp_sec_q <= 16'h0;
          slp_hr_q  <= 3'h0;
          if (!thr_n || !sleep_ok)
          begin
            // second phase restarts too, so a timeout never ends early
            ms_q  <= 10'h0;
            sec_q <= 16'h0;
            min_q <= 6'h0;
          end
          else if (sec_tick)
          begin
            if (sec_q == `SBT_SEC_PER_MIN - 16'h1)
            begin
              sec_q <= 16'h0;
              min_q <= min_q + 6'h1;
            end
            else
              sec_q <= sec_q + 16'h1;
          end
          if (sleep_ok && thr_n && min_q >= sleep_min_in)
          begin
            state_q        <= ST_SLEEP;
            asleep_out     <= 1'b1;
            enter_q        <= 1'b1;
            key_off_seen_q <= 1'b0;
            flash_ms_q     <= 16'h0;
          end
        end
        ST_SLEEP:
        begin
          if (!key_s)
            key_off_seen_q <= 1'b1;
          if (ms_tick)
            flash_ms_q <= (flash_ms_q == `SBT_FLASH_PERIOD_S * `SBT_MS_PER_SEC - 16'h1) ?
                          16'h0 : flash_ms_q + 16'h1;
          status_flash_out <= (wake_style_in == `SBT_WAKE_KEY_THR) &&
                              (flash_ms_q < `SBT_FLASH_ON_MS);
          if (sec_tick)
          begin
            if (slp_sec_q == `SBT_SEC_PER_HOUR - 16'h1)
            begin
              slp_sec_q <= 16'h0;
              if (slp_hr_q != 3'h7)
                slp_hr_q <= slp_hr_q + 3'h1;
            end
            else
              slp_sec_q <= slp_sec_q + 16'h1;
          end
          if (poweroff_en_in && slp_hr_q >= `SBT_POWEROFF_HOURS)
            power_off_out <= 1'b1;
          if (wake)
          begin
            state_q    <= ST_AWAKE;
            asleep_out <= 1'b0;
            ms_q       <= 10'h0;
            sec_q      <= 16'h0;
            min_q      <= 6'h0;
          end
        end
        default:
          state_q <= ST_AWAKE;
      endcase
    end
  end

  // throttle interpretation
  reg       cmd_rev;
  reg [7:0] cmd_mag;
  always @*
  begin
    cmd_mag = thr_n ? 8'h00 : thr_mag_in;
    case (thr_type_in)
      `SBT_TT_BIDIR:    cmd_rev = thr_side_in ^ swap_dir_in;
      `SBT_TT_SINGLE:   cmd_rev = sw_rev;
      `SBT_TT_UNIPOLAR: cmd_rev = sw_rev;
      default:          cmd_rev = thr_side_in;
    endcase
  end

  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      drive_mag_out <= 8'h00;
      drive_rev_out <= 1'b0;
      motor_rev_out <= 1'b0;
    end
    else
    begin
      drive_mag_out <= (asleep_out || state_q == ST_SLEEP) ? 8'h00 : cmd_mag;
      drive_rev_out <= cmd_rev;
      motor_rev_out <= cmd_rev ^ motor_rev_in;
    end
  end

  // beeper sequencer
  localparam BP_IDLE  = 4'b0001;
  localparam BP_ON    = 4'b0010;
  localparam BP_OFF   = 4'b0100;
  localparam BP_LONG  = 4'b1000;
  reg [3:0]  bp_q;
  reg [10:0] bp_ms_q;
  reg [3:0]  code_left_q;

  wire mot_beep = moving_in && drive_rev_out ?
                  (rev_beep_en_in || motion_beep_in != `SBT_MB_NONE) :
                  moving_in && (motion_beep_in == `SBT_MB_ANY);
  wire cont_beep = mot_beep || (dd_beep_en_in && batt_low_in);
  wire code_beep = flash_beep_en_in && (flash_code_in != 4'h0);
  wire on_done  = ms_tick && (bp_ms_q + 11'h1 >= beep_on_ms_in);
  wire off_done = ms_tick && (bp_ms_q + 11'h1 >= beep_off_ms_in);

  always @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      bp_q        <= BP_IDLE;
      bp_ms_q     <= 11'h0;
      code_left_q <= 4'h0;
      beeper_out  <= 1'b0;
    end
    else if (!beep_en_in)
    begin
      bp_q       <= BP_IDLE;
      bp_ms_q    <= 11'h0;
      beeper_out <= 1'b0;
    end
    else
    begin
      if (ms_tick)
        bp_ms_q <= bp_ms_q + 11'h1;
      case (bp_q)
        BP_IDLE:
        begin
          beeper_out <= 1'b0;
          bp_ms_q    <= 11'h0;
          if (enter_q && sleep_beep_en_in)
          begin
            bp_q       <= BP_LONG;
            beeper_out <= 1'b1;
          end
          else if (code_beep || cont_beep)
          begin
            bp_q        <= BP_ON;
            beeper_out  <= 1'b1;
            code_left_q <= code_beep ? flash_code_in - 4'h1 : 4'h0;
          end
        end
        BP_ON:
          if (on_done)
          begin
            bp_q       <= BP_OFF;
            bp_ms_q    <= 11'h0;
            beeper_out <= 1'b0;
          end
        BP_OFF:
          if (off_done || beep_off_ms_in == 11'h0)
          begin
            bp_ms_q <= 11'h0;
            if (code_beep && code_left_q != 4'h0)
            begin
              code_left_q <= code_left_q - 4'h1;
              bp_q        <= BP_ON;
              beeper_out  <= 1'b1;
            end
            else if (cont_beep)
            begin
              bp_q       <= BP_ON;
              beeper_out <= 1'b1;
            end
            else
              bp_q <= BP_IDLE;
          end
        BP_LONG:
          if (ms_tick && bp_ms_q + 11'h1 >= `SBT_SLEEP_BEEP_MS)
          begin
            bp_q       <= BP_IDLE;
            beeper_out <= 1'b0;
          end
        default:
          bp_q <= BP_IDLE;
      endcase
      // sleep entry beep
      // takes over any phase in progress so the entry is never silent
      if (enter_q && sleep_beep_en_in)
      begin
        bp_q       <= BP_LONG;
        bp_ms_q    <= 11'h0;
        beeper_out <= 1'b1;
      end
    end
  end
endmodule

/* File: dv/sbt_asserts.sv */
`timescale 1ns/100ps
module sbt_asserts #(
  parameter MS_DIV = 10
) (
  input wire       mclk_in, // clock
  input wire       rst_n_in, // reset
  input wire       thr_neutral_in, // neutral
  input wire [5:0] sleep_min_in, // timeout
  input wire       fault_in, // fault
  input wire       throttle_fault_in, // thr fault
  input wire       neutral_at_powerup_fault_in, // power-up
  input wire       sleep_on_fault_in, // sleep ok
  input wire       beep_en_in, // master
  input wire       motor_rev_in, // motor rev
  input wire       poweroff_en_in, // off enable
  input wire       asleep_out, // asleep
  input wire [7:0] drive_mag_out, // demand
  input wire       drive_rev_out, // direction
  input wire       motor_rev_out, // motor dir
  input wire       beeper_out, // beeper
  input wire       status_flash_out, // flash
  input wire       power_off_out // off
);
  reg [31:0] idle_q;
  // counts from the pin, so it leads the design's synchronised count
  always @(posedge mclk_in)
  begin
    // also restarts wherever sleep is barred or already taken
    if (!rst_n_in || !thr_neutral_in || asleep_out || sleep_min_in == 6'h00 ||
        throttle_fault_in || neutral_at_powerup_fault_in || (fault_in && !sleep_on_fault_in))
      idle_q <= 32'h0;
    else
      idle_q <= idle_q + 32'h1;
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  sleep_early_a: assert property ($rose(asleep_out) |->
    idle_q >= sleep_min_in * 32'h0000ea60 * MS_DIV)
    else $error("sleep entered early");
  sleep_late_a: assert property ($rose(asleep_out) |->
    idle_q <= (sleep_min_in * 32'h3c + 32'h2) * 32'h3e8 * MS_DIV)
    else $error("sleep entry too late");
  sleep_mute_a: assert property (asleep_out |-> drive_mag_out == 8'h00)
    else $error("drive demand while asleep");
  awake_flash_a: assert property (!asleep_out [*3] |-> !status_flash_out)
    else $error("status flash while awake");
  zero_timeout_a: assert property ($past(sleep_min_in == 6'h00) |-> !$rose(asleep_out))
    else $error("sleep with zero timeout");
  motor_flip_a: assert property ($stable(motor_rev_in) [*3] |-> (motor_rev_out ^ drive_rev_out) == motor_rev_in)
    else $error("motor polarity mismatch");
  beep_mute_a: assert property (!beep_en_in [*3] |-> !beeper_out)
    else $error("beep with master enable off");
  fault_awake_a: assert property ($past(fault_in && !sleep_on_fault_in) |->
    !$rose(asleep_out))
    else $error("sleep during fault");
  thr_fault_a: assert property ($past(throttle_fault_in || neutral_at_powerup_fault_in) |->
    !$rose(asleep_out))
    else $error("sleep during throttle fault");
  poweroff_gate_a: assert property (!poweroff_en_in |-> !$rose(power_off_out))
    else $error("power off not enabled");
  cover property ($rose(asleep_out));
  cover property ($rose(beeper_out));
  cover property ($rose(status_flash_out));
endmodule

bind sbt_core sbt_asserts #(.MS_DIV(MS_DIV)) u_sbt_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .thr_neutral_in(thr_neutral_in),
  .sleep_min_in(sleep_min_in), .fault_in(fault_in), .throttle_fault_in(throttle_fault_in),
  .neutral_at_powerup_fault_in(neutral_at_powerup_fault_in),
  .sleep_on_fault_in(sleep_on_fault_in), .beep_en_in(beep_en_in),
  .motor_rev_in(motor_rev_in), .poweroff_en_in(poweroff_en_in), .asleep_out(asleep_out),
  .drive_mag_out(drive_mag_out), .drive_rev_out(drive_rev_out),
  .motor_rev_out(motor_rev_out), .beeper_out(beeper_out),
  .status_flash_out(status_flash_out), .power_off_out(power_off_out)
);

/* File: dv/sbt_user.sv */
`timescale 1ns/100ps
// rider side: key, throttle lever and an ear counting beeps
module sbt_user (
  input  wire       mclk_in, // clock
  input  wire       key_req_in, // key wanted on
  input  wire       push_in, // lever out of neutral
  input  wire       side_req_in, // lever to reverse side
  input  wire       beeper_in, // beeper drive
  input  wire       clr_in, // clear beep count
  output reg        key_on_out = 1'b0, // key pin
  output reg        neutral_out = 1'b1, // neutral window
  output reg        side_out = 1'b0, // deflection side
  output reg  [7:0] mag_out = 8'h00, // magnitude
  output reg  [7:0] beeps_out = 8'h00 // beep onsets
);
  reg beep_q = 1'b0;
  always @(posedge mclk_in)
  begin
    key_on_out  <= key_req_in;
    neutral_out <= !push_in;
    side_out    <= side_req_in;
    // a lever at rest reads no magnitude
    mag_out     <= push_in ? 8'h40 : 8'h00;
    beep_q      <= beeper_in;
    beeps_out   <= clr_in ? 8'h00 : beeps_out + {7'h00, beeper_in & ~beep_q};
  end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done = checks_done + 1; if ((g) !== (e)) begin \
  fails = fails + 1; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  reg        mclk_in = 1'b0, rst_n_in = 1'b0, key_q = 1'b1, push_q = 1'b0, side_q = 1'b0;
  reg        clr_q = 1'b0, sw_q = 1'b0, batt_q = 1'b0, mov_q = 1'b0, wake_q = 1'b0;
  reg        swap_q = 1'b0, mrev_q = 1'b0, ben_q = 1'b0, fben_q = 1'b0, sben_q = 1'b0;
  reg        rben_q = 1'b0, dd_q = 1'b0, flt_q = 1'b0, sof_q = 1'b0;
  reg [3:0]  code_q = 4'h0;
  reg [5:0]  smin_q = 6'h00;
  reg [1:0]  tt_q = 2'h0, mb_q = 2'h0;
  wire       key_w, neut_w, side_w, sleep_w, drev_w, mrev_w, beep_w, flash_w;
  wire [7:0] mag_w, dmag_w, beeps_w;
  wire [2:0] obs_w = {flash_w, sleep_w, beep_w};
  integer    fails = 0, checks_done = 0, i, n;
  // ms tick every cycle keeps a one-minute sleep inside the run
  sbt_core #(.MS_DIV(1)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .key_on_in(key_w), .thr_neutral_in(neut_w),
    .thr_side_in(side_w), .thr_mag_in(mag_w), .fwd_rev_sw_in(sw_q), .fault_in(flt_q),
    .throttle_fault_in(1'b0), .neutral_at_powerup_fault_in(1'b0), .flash_code_in(code_q),
    .batt_low_in(batt_q), .moving_in(mov_q), .sleep_min_in(smin_q), .wake_style_in(wake_q),
    .swap_dir_in(swap_q), .motor_rev_in(mrev_q), .thr_type_in(tt_q), .beep_en_in(ben_q),
    .flash_beep_en_in(fben_q), .sleep_beep_en_in(sben_q), .rev_beep_en_in(rben_q),
    .motion_beep_in(mb_q), .dd_beep_en_in(dd_q), .beep_on_ms_in(11'h064),
    .beep_off_ms_in(11'h032), .sleep_on_fault_in(sof_q), .poweroff_en_in(1'b0),
    .asleep_out(sleep_w), .drive_mag_out(dmag_w), .drive_rev_out(drev_w),
    .motor_rev_out(mrev_w), .beeper_out(beep_w), .status_flash_out(flash_w),
    .power_off_out()
  );
  sbt_user u_user (
    .mclk_in(mclk_in), .key_req_in(key_q), .push_in(push_q), .side_req_in(side_q),
    .beeper_in(beep_w), .clr_in(clr_q), .key_on_out(key_w), .neutral_out(neut_w),
    .side_out(side_w), .mag_out(mag_w), .beeps_out(beeps_w)
  );
  initial
  begin
    forever #50 mclk_in = ~mclk_in;
  end
  task cyc(input integer k);
  begin
    repeat (k) @(posedge mclk_in);
    #1;
  end
  endtask
  // waits while an observed output holds level v, at most lim cycles
  task run(input [1:0] s, input v, input integer lim, output integer len);
  begin
    len = 0;
    while (obs_w[s] === v && len < lim)
    begin
      cyc(1);
      len = len + 1;
    end
  end
  endtask
  task clr_beeps;
  begin
    clr_q = 1'b1;
    cyc(1);
    clr_q = 1'b0;
  end
  endtask
  task t_dir;
  begin
    push_q = 1'b1;
    for (i = 0; i < 48; i = i + 1)
    begin
      tt_q = i[5:4];
      {side_q, swap_q, sw_q, mrev_q} = i[3:0];
      cyc(8);
      n = (tt_q == 2'h0) ? (side_q ^ swap_q) : sw_q;
      `CHK(drev_w, n[0])
      `CHK(mrev_w, n[0] ^ mrev_q)
      `CHK(dmag_w, 8'h40)
    end
    $display("direction test done");
  end
  endtask
  task t_beep;
  begin
    {tt_q, swap_q, mrev_q, dd_q} = 5'h01;
    for (i = 0; i < 64; i = i + 1)
      if (i[3:2] != 2'h3)
      begin
        {batt_q, side_q, mb_q, rben_q, ben_q} = i[5:0];
        mov_q = !batt_q;
        clr_beeps;
        cyc(150);
        n = ben_q && (batt_q || mb_q == 2'h2 || (side_q && (rben_q || mb_q == 2'h1)));
        `CHK(beeps_w != 8'h00, n[0])
        {ben_q, batt_q, mov_q} = 3'h0;
        cyc(160);
      end
    $display("beep enable test done");
  end
  endtask
  task t_time;
  begin
    {ben_q, mb_q, mov_q} = 4'hd;
    run(2'h0, 1'b0, 300, n);
    run(2'h0, 1'b1, 3000, n);
    `CHK(n >= 99 && n <= 101, 1'b1)
    run(2'h0, 1'b0, 3000, n);
    `CHK(n >= 49 && n <= 51, 1'b1)
    cyc(20);
    mov_q = 1'b0;
    run(2'h0, 1'b1, 3000, n);
    `CHK(n >= 78 && n <= 81, 1'b1)
    run(2'h0, 1'b0, 3000, n);
    `CHK(n, 3000)
    $display("beep timing test done");
  end
  endtask
  task t_flash;
  begin
    clr_beeps;
    {fben_q, code_q} = 5'h13;
    cyc(445);
    `CHK(beeps_w, 8'h03)
    {fben_q, code_q} = 5'h00;
    cyc(200);
    code_q = 4'h3;
    clr_beeps;
    cyc(300);
    `CHK(beeps_w, 8'h00)
    code_q = 4'h0;
    $display("flash code test done");
  end
  endtask
  task t_sleep;
  begin
    {ben_q, sben_q, wake_q, push_q, key_q, smin_q} = 11'h641;
    // an active fault with sleep-on-fault allowed must not hold sleep off
    {flt_q, sof_q} = 2'h3;
    cyc(59000);
    `CHK(sleep_w, 1'b0)
    run(2'h1, 1'b0, 3000, n);
    `CHK(sleep_w, 1'b1)
    cyc(5);
    `CHK(beep_w, 1'b1)
    cyc(900);
    `CHK(beep_w, 1'b1)
    cyc(200);
    `CHK(beep_w, 1'b0)
    run(2'h2, 1'b0, 5100, n);
    `CHK(flash_w, 1'b1)
    {wake_q, push_q} = 2'h3;
    cyc(20);
    `CHK(sleep_w, 1'b1)
    `CHK(dmag_w, 8'h00)
    key_q = 1'b0;
    cyc(10);
    key_q = 1'b1;
    cyc(10);
    `CHK(sleep_w, 1'b0)
    $display("sleep test done");
  end
  endtask
  task stop_test;
  begin
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  initial
  begin
    cyc(11);
    `CHK({sleep_w, dmag_w, drev_w, mrev_w, beep_w, flash_w}, 13'h0000)
    cyc(1);
    rst_n_in = 1'b1;
    t_dir;
    t_beep;
    t_time;
    t_flash;
    t_sleep;
    stop_test;
  end
  // about 85k cycles expected; cut off just beyond that
  initial
  begin
    #9500000;
    fails = fails + 1;
    $display("watchdog expired");
    stop_test;
  end
endmodule
